/* File: core/utd_top.sv */
// undertorque detector with avalon-mm registers and output terminals
// Notes on behaviour
// [R1] mode zero: no detection, no alarm/fault
// [R2] modes 1,2: detect at constant speed only
// [R3] modes 3,4: detect throughout running incl. accel
// [R4] modes 1,3: continue, blinking alarm while detected
// [R5] modes 2,4: stopping fault, indication steadily lit
// [R6] threshold in 1% of rated current, default 10
// [R7] torque source: threshold relative to rated torque
// [R8] declare after below threshold longer than time
// [R9] release only above threshold plus 5%; the code also releases when detection turns inapplicable
// [R10] output code 8 normally-open, 9 normally-closed
// [R11] vector mode: source 0 torque, 1 current
// [R12] v/f mode: always use output current
// [R13] clear timer on leaving region or inapplicable
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module utd_top #(
    parameter int TICK_COUNT = utd_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] current_pct,
    input wire logic [7:0] torque_pct,
    input wire logic running,
    input wire logic at_speed,
    output logic undertorque_indication,
    output logic blink_alarm,
    output logic drive_stop_fault,
    output logic relay_contact_a,
    output logic relay_contact_b,
    output logic photocoupler_out_1,
    output logic photocoupler_out_2,
    output logic irq
);
    // software-visible settings
    logic [2:0] undertorque_mode_select_r;
    logic [7:0] undertorque_level_r;
    logic [7:0] undertorque_time_r;
    logic torque_detect_source_r;
    logic vector_mode_r;
    logic [4:0] output_function_select_a_r;
    logic [4:0] output_function_select_b_r;
    logic [4:0] output_function_select_c_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic ack_r;

    // detector state
    utd_pkg::utd_state_e state_r;
    utd_pkg::utd_state_e state_nxt;
    logic [7:0] low_ticks_r;
    logic fault_r;
    logic [2:0] blink_cnt_r;
    logic blink_r;
    logic tick;

    utd_tick #(
        .COUNT(TICK_COUNT)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    function automatic logic out_level(input logic [4:0] fsel,
                                       input logic det);
        if (fsel == utd_pkg::OUTFN_UT_NO)
            return det; // R10
        else if (fsel == utd_pkg::OUTFN_UT_NC)
            return ~det; // R10
        else
            return 1'b0;
    endfunction

    // monitored quantity selection
    wire use_torque = vector_mode_r & ~torque_detect_source_r; // R11 R12
    // same percent threshold, scaled to rated torque when torque is used
    wire [7:0] monitored = use_torque ? torque_pct : current_pct; // R7
    wire [8:0] release_lvl = {1'b0, undertorque_level_r}
                           + {1'b0, utd_pkg::HYST_PCT};
    wire below = monitored < undertorque_level_r; // R6
    wire above_release = {1'b0, monitored} > release_lvl; // R9

    wire mode_cs = (undertorque_mode_select_r == utd_pkg::MODE_CS_ALARM)
                 | (undertorque_mode_select_r == utd_pkg::MODE_CS_FAULT);
    wire mode_run = (undertorque_mode_select_r == utd_pkg::MODE_RUN_ALARM)
                  | (undertorque_mode_select_r == utd_pkg::MODE_RUN_FAULT);
    wire mode_fault = (undertorque_mode_select_r == utd_pkg::MODE_CS_FAULT)
                    | (undertorque_mode_select_r == utd_pkg::MODE_RUN_FAULT);
    // phase gating
    wire applicable = running & ((mode_cs & at_speed) // R2
                               | mode_run); // R3 R1
    wire timer_done = low_ticks_r > undertorque_time_r; // R8
    wire detected = (state_r == utd_pkg::ST_DET);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            utd_pkg::ST_IDLE: begin
                if (applicable && below)
                    state_nxt = utd_pkg::ST_LOW;
            end
            utd_pkg::ST_LOW: begin
                if (!applicable || !below)
                    state_nxt = utd_pkg::ST_IDLE; // R13
                else if (timer_done)
                    state_nxt = utd_pkg::ST_DET; // R8
            end
            utd_pkg::ST_DET: begin
                if (!applicable || above_release)
                    state_nxt = utd_pkg::ST_IDLE; // R9
            end
            default: state_nxt = utd_pkg::ST_IDLE;
        endcase
    end

    wire enter_det = (state_r == utd_pkg::ST_LOW)
                   && (state_nxt == utd_pkg::ST_DET);
    wire alarm_evt = enter_det & ~mode_fault;
    wire fault_evt = enter_det & mode_fault;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= utd_pkg::ST_IDLE;
            low_ticks_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != utd_pkg::ST_LOW)
                low_ticks_r <= 8'h00; // R13
            else if (tick && low_ticks_r != 8'hFF)
                low_ticks_r <= low_ticks_r + 8'h01; // R8
        end
    end

    // fault latches and holds the drive stopped until cleared
    wire fault_clr = ack_r == 1'b0 && avs_write
                   && avs_address == utd_pkg::OFS_CTRL
                   && avs_writedata[utd_pkg::CTRL_FLT_CLR_BIT];
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            fault_r <= 1'b0;
        else if (fault_evt)
            fault_r <= 1'b1; // R5
        else if (fault_clr)
            fault_r <= 1'b0;
    end

    // blink generator for the alarm display
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            blink_cnt_r <= 3'h0;
            blink_r <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_r == 3'(utd_pkg::BLINK_TICKS - 1)) begin
                blink_cnt_r <= 3'h0;
                blink_r <= ~blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 3'h1;
            end
        end
    end

    wire alarm_on = detected & ~mode_fault; // R4
    wire ind = fault_r | alarm_on;
    wire ind_disp = fault_r | (alarm_on & blink_r); // R4 R5

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            undertorque_indication <= 1'b0;
            blink_alarm <= 1'b0;
            drive_stop_fault <= 1'b0;
            relay_contact_a <= 1'b0;
            relay_contact_b <= 1'b0;
            photocoupler_out_1 <= 1'b0;
            photocoupler_out_2 <= 1'b0;
        end else begin
            undertorque_indication <= ind_disp;
            blink_alarm <= alarm_on; // R4
            drive_stop_fault <= fault_r; // R5
            relay_contact_a <= out_level(output_function_select_a_r, ind);
            relay_contact_b <= ~out_level(output_function_select_a_r, ind);
            photocoupler_out_1 <= out_level(output_function_select_b_r, ind);
            photocoupler_out_2 <= out_level(output_function_select_c_r, ind);
        end
    end

    // avalon-mm slave: one wait cycle, answer on the second edge
    wire access = (avs_read | avs_write) & ~ack_r;
    wire wr = avs_write & ~ack_r;
    wire sel_ctrl = avs_address == utd_pkg::OFS_CTRL;
    wire sel_lvl = avs_address == utd_pkg::OFS_LEVEL;
    wire sel_time = avs_address == utd_pkg::OFS_TIME;
    wire sel_out = avs_address == utd_pkg::OFS_OUTSEL;
    wire sel_ist = avs_address == utd_pkg::OFS_IRQ_ST;
    wire sel_msk = avs_address == utd_pkg::OFS_IRQ_MSK;
    wire [1:0] w1c = (wr & sel_ist) ? avs_writedata[1:0] : 2'b00;
    wire [1:0] evt = {fault_evt, alarm_evt};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            utd_pkg::OFS_CTRL: rd_mux = {26'h0, vector_mode_r,
                torque_detect_source_r, 1'b0, undertorque_mode_select_r};
            utd_pkg::OFS_LEVEL: rd_mux = {24'h0, undertorque_level_r};
            utd_pkg::OFS_TIME: rd_mux = {24'h0, undertorque_time_r};
            utd_pkg::OFS_OUTSEL: rd_mux = {11'h0,
                output_function_select_c_r, 3'h0,
                output_function_select_b_r, 3'h0,
                output_function_select_a_r};
            utd_pkg::OFS_STAT: rd_mux = {16'h0, low_ticks_r, 2'h0,
                fault_r, alarm_on, 1'b0, state_r};
            utd_pkg::OFS_IRQ_ST: rd_mux = {30'h0, irq_status_r};
            utd_pkg::OFS_IRQ_MSK: rd_mux = {30'h0, irq_mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_r <= access;
            // registered copy of not(access) keeps the port on a flop
            avs_waitrequest <= ~access;
            if (access)
                avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            undertorque_mode_select_r <= utd_pkg::MODE_RST;
            torque_detect_source_r <= 1'b0;
            vector_mode_r <= 1'b0;
            undertorque_level_r <= utd_pkg::LEVEL_RST; // R6
            undertorque_time_r <= utd_pkg::TIME_RST; // R8
            output_function_select_a_r <= utd_pkg::OUTSEL_RST;
            output_function_select_b_r <= utd_pkg::OUTSEL_RST;
            output_function_select_c_r <= utd_pkg::OUTSEL_RST;
            irq_mask_r <= 2'b00;
        end else if (wr) begin
            if (sel_ctrl) begin
                undertorque_mode_select_r <= avs_writedata[2:0];
                torque_detect_source_r <= avs_writedata[4];
                vector_mode_r <= avs_writedata[5];
            end
            if (sel_lvl)
                undertorque_level_r <= avs_writedata[7:0];
            if (sel_time)
                undertorque_time_r <= avs_writedata[7:0];
            if (sel_out) begin
                output_function_select_a_r <= avs_writedata[4:0];
                output_function_select_b_r <= avs_writedata[12:8];
                output_function_select_c_r <= avs_writedata[20:16];
            end
            if (sel_msk)
                irq_mask_r <= avs_writedata[1:0];
        end
    end

    // set beats clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_status_r <= 2'b00;
            irq <= 1'b0;
        end else begin
            irq_status_r <= (irq_status_r & ~w1c) | evt;
            irq <= |(((irq_status_r & ~w1c) | evt) & irq_mask_r);
        end
    end
endmodule

/* File: inc/utd_pkg.sv */
// shared constants and types for the undertorque detector
package utd_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_LEVEL = 5'h04;
    localparam logic [4:0] OFS_TIME = 5'h08;
    localparam logic [4:0] OFS_OUTSEL = 5'h0C;
    localparam logic [4:0] OFS_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_ST = 5'h14;
    localparam logic [4:0] OFS_IRQ_MSK = 5'h18;
    // ctrl field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_BIT = 4;
    localparam int CTRL_VEC_BIT = 5;
    localparam int CTRL_FLT_CLR_BIT = 8;
    // reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] LEVEL_RST = 8'h0A;
    localparam logic [7:0] TIME_RST = 8'h01;
    localparam logic [4:0] OUTSEL_RST = 5'h00;
    // mode selector codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_CS_ALARM = 3'h1;
    localparam logic [2:0] MODE_CS_FAULT = 3'h2;
    localparam logic [2:0] MODE_RUN_ALARM = 3'h3;
    localparam logic [2:0] MODE_RUN_FAULT = 3'h4;
    // output function codes
    localparam logic [4:0] OUTFN_UT_NO = 5'h08;
    localparam logic [4:0] OUTFN_UT_NC = 5'h09;
    // release hysteresis in percent
    localparam logic [7:0] HYST_PCT = 8'h05;
    // time base: detection time counts in 0.1 s steps
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    // blink half period
    localparam int BLINK_MS = 500;
    localparam int BLINK_TICKS = BLINK_MS / TICK_MS;
    // irq bits
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_FAULT = 1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_DET = 3'b100
    } utd_state_e;
endpackage

/* File: core/utd_tick.sv */
// divider producing a one-cycle enable every count cycles
`timescale 1ns/1ns
module utd_tick #(
    parameter int COUNT = 2_000_000
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic tick
);
    localparam int W = $clog2(COUNT);
    logic [W-1:0] cnt_r;
    wire wrap = (cnt_r == W'(COUNT - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= wrap ? '0 : cnt_r + 1'b1;
            tick <= wrap;
        end
    end
endmodule

/* File: test/utd_asserts.sv */
// property checks on the undertorque detector ports
`timescale 1ns/1ns
module utd_asserts #(
    parameter int TICK_COUNT = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] current_pct,
    input wire logic [7:0] torque_pct,
    input wire logic running,
    input wire logic at_speed,
    input wire logic undertorque_indication,
    input wire logic blink_alarm,
    input wire logic drive_stop_fault,
    input wire logic photocoupler_out_1,
    input wire logic photocoupler_out_2
);
    logic [5:0] ctl_r;
    logic [7:0] lvl_r, tm_r;
    logic [4:0] sb_r, sc_r;
    logic [31:0] low_r;
    wire wr = avs_write && !avs_waitrequest;
    wire [7:0] val = ctl_r[5:4] == 2'h2 ? torque_pct : current_pct;
    wire [2:0] md = ctl_r[2:0];
    wire alm_md = md == 3'h1 || md == 3'h3;
    wire flt_md = md == 3'h2 || md == 3'h4;
    wire cs_md = md == 3'h1 || md == 3'h2;
    wire det = blink_alarm || drive_stop_fault;
    // shadows lag the design by one edge, hence the repetitions below
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_r <= 6'h00;
            lvl_r <= utd_pkg::LEVEL_RST;
            tm_r <= utd_pkg::TIME_RST;
            sb_r <= 5'h00;
            sc_r <= 5'h00;
            low_r <= 32'h0;
        end else begin
            if (wr && avs_address == utd_pkg::OFS_CTRL)
                ctl_r <= avs_writedata[5:0];
            if (wr && avs_address == utd_pkg::OFS_LEVEL)
                lvl_r <= avs_writedata[7:0];
            if (wr && avs_address == utd_pkg::OFS_TIME)
                tm_r <= avs_writedata[7:0];
            if (wr && avs_address == utd_pkg::OFS_OUTSEL) begin
                sb_r <= avs_writedata[12:8];
                sc_r <= avs_writedata[20:16];
            end
            low_r <= val < lvl_r ? low_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_OFF: assert property ((md == 3'h0)[*3] |-> !blink_alarm)
        else $error("alarm while detection off");
    AST_CS: assert property ((cs_md && !at_speed)[*3] |-> !$rose(det))
        else $error("detection outside constant speed");
    AST_RUN: assert property ($rose(det) |-> $past(running))
        else $error("detection while stopped");
    AST_ALM: assert property ($rose(blink_alarm) |-> $past(alm_md))
        else $error("alarm in wrong mode");
    AST_FLT: assert property ($rose(drive_stop_fault) |-> $past(flt_md))
        else $error("fault in wrong mode");
    AST_LIT: assert property (drive_stop_fault[*2] |-> undertorque_indication)
        else $error("fault indication not lit");
    AST_NO: assert property (
        (sb_r == 5'h08 && $stable(det))[*3] |-> photocoupler_out_1 == det)
        else $error("open contact output wrong");
    AST_NC: assert property (
        (sc_r == 5'h09 && $stable(det))[*3] |-> photocoupler_out_2 != det)
        else $error("closed contact output wrong");
    AST_TIME: assert property (
        $rose(det) |-> $past(low_r, 2) + 8 >= tm_r * TICK_COUNT)
        else $error("detection too early");
endmodule
bind utd_top utd_asserts #(.TICK_COUNT(TICK_COUNT)) chk_u (
    .core_clk, .sys_rst, .avs_address, .avs_write, .avs_writedata,
    .avs_waitrequest, .current_pct, .torque_pct, .running, .at_speed,
    .undertorque_indication, .blink_alarm, .drive_stop_fault,
    .photocoupler_out_1, .photocoupler_out_2);

/* File: test/utd_motor.sv */
// motor side: run status, acceleration ramp and measured load
`timescale 1ns/1ns
module utd_motor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run_cmd,
    input wire logic [15:0] ramp,
    input wire logic [7:0] cur_set,
    input wire logic [7:0] trq_set,
    output logic [7:0] current_pct,
    output logic [7:0] torque_pct,
    output logic running,
    output logic at_speed
);
    logic [15:0] acc_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !run_cmd) begin
            acc_r <= 16'h0000;
            running <= 1'b0;
            at_speed <= 1'b0;
            current_pct <= 8'h00;
            torque_pct <= 8'h00;
        end else begin
            running <= 1'b1;
            acc_r <= acc_r + 16'(acc_r < ramp);
            at_speed <= acc_r >= ramp;
            current_pct <= cur_set;
            torque_pct <= trq_set;
        end
    end
endmodule

/* File: test/tb.sv */
// self-checking bench for the undertorque detector
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module tb;
    localparam int TC = 20;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, running, at_speed, irq, pv;
    logic [7:0] current_pct, torque_pct;
    logic undertorque_indication, blink_alarm, drive_stop_fault;
    logic relay_contact_a, relay_contact_b;
    logic photocoupler_out_1, photocoupler_out_2;
    logic run_cmd = 1'b0;
    logic [15:0] ramp = 16'h0000;
    logic [7:0] cur_set = 8'h00, trq_set = 8'h00;
    logic [31:0] rs = 32'hA81AC478;
    int errors = 0, checks = 0, lvl = 10, tm = 1;
    always #25 core_clk = ~core_clk;
    utd_top #(.TICK_COUNT(TC)) dut_u (.core_clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .current_pct, .torque_pct, .running, .at_speed,
        .undertorque_indication, .blink_alarm, .drive_stop_fault,
        .relay_contact_a, .relay_contact_b, .photocoupler_out_1,
        .photocoupler_out_2, .irq);
    utd_motor mot_u (.core_clk, .sys_rst, .run_cmd, .ramp, .cur_set,
        .trq_set, .current_pct, .torque_pct, .running, .at_speed);
    // heavy load well above the release band
    function automatic logic [7:0] hi();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return 8'h1E + 8'(rs % 60);
    endfunction
    task automatic bus(input bit w, input [4:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50) errors++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input [4:0] a, input [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic ut(input [2:0] m, input [1:0] vs, input [7:0] c,
                      input [7:0] t, input [15:0] rp);
        int v, hit, n, ones;
        v = vs == 2'h2 ? t : c;
        hit = m != 0 && v < lvl && (m > 2 || rp < 40);
        n = 0;
        ones = 0;
        bus(1'b1, utd_pkg::OFS_CTRL, {26'h0, vs, 1'b0, m});
        cur_set <= c;
        trq_set <= t;
        ramp <= rp;
        run_cmd <= 1'b1;
        repeat ((tm + 3) * TC) @(posedge core_clk);
        pv = undertorque_indication;
        for (int i = 0; i < 220; i++) begin
            @(posedge core_clk);
            ones += undertorque_indication;
            n += undertorque_indication != pv;
            pv = undertorque_indication;
        end
        `CHK(blink_alarm, hit && m[0])
        `CHK(drive_stop_fault, hit && !m[0])
        `CHK(n > 1, hit && m[0])
        `CHK(ones == 220, hit && !m[0])
        `CHK(photocoupler_out_1, hit != 0)
        `CHK(relay_contact_a, hit != 0)
        `CHK(relay_contact_b, hit == 0)
        `CHK(photocoupler_out_2, hit == 0)
        run_cmd <= 1'b0;
        // fault stays latched until software clears it
        bus(1'b1, utd_pkg::OFS_CTRL, 32'h100);
        repeat (2 * TC) @(posedge core_clk);
        `CHK({blink_alarm, drive_stop_fault}, 2'b00)
    endtask
    task automatic test_done;
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(utd_pkg::OFS_LEVEL, 32'h0A);
        rd(utd_pkg::OFS_TIME, 32'h01);
        rd(5'h1C, 32'h0);
        bus(1'b1, utd_pkg::OFS_OUTSEL, 32'h00090808);
        rd(utd_pkg::OFS_OUTSEL, 32'h00090808);
        bus(1'b1, utd_pkg::OFS_IRQ_MSK, 32'h3);
        ut(3'h0, 2'h0, 8'h02, 8'h02, 16'h0002);
        ut(3'h1, 2'h0, 8'h02, hi(), 16'h03E8);
        ut(3'h2, 2'h0, 8'h02, hi(), 16'h03E8);
        ut(3'h3, 2'h0, 8'h02, hi(), 16'h03E8);
        ut(3'h4, 2'h0, 8'h02, hi(), 16'h03E8);
        ut(3'h1, 2'h0, 8'h09, hi(), 16'h0002);
        ut(3'h1, 2'h0, 8'h0A, hi(), 16'h0002);
        ut(3'h2, 2'h0, 8'h05, hi(), 16'h0002);
        ut(3'h1, 2'h2, hi(), 8'h05, 16'h0002);
        ut(3'h1, 2'h3, hi(), 8'h05, 16'h0002);
        ut(3'h1, 2'h0, hi(), 8'h05, 16'h0002);
        rd(utd_pkg::OFS_IRQ_ST, 32'h3);
        `CHK(irq, 1'b1)
        bus(1'b1, utd_pkg::OFS_IRQ_MSK, 32'h0);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        bus(1'b1, utd_pkg::OFS_IRQ_MSK, 32'h3);
        bus(1'b1, utd_pkg::OFS_IRQ_ST, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        bus(1'b1, utd_pkg::OFS_CTRL, 32'h1);
        cur_set <= 8'h09;
        run_cmd <= 1'b1;
        repeat (5 * TC) @(posedge core_clk);
        `CHK(blink_alarm, 1'b1)
        cur_set <= 8'h0E;
        repeat (4 * TC) @(posedge core_clk);
        `CHK(blink_alarm, 1'b1)
        cur_set <= 8'h10;
        repeat (3 * TC) @(posedge core_clk);
        `CHK(blink_alarm, 1'b0)
        tm = 2;
        bus(1'b1, utd_pkg::OFS_TIME, 32'h2);
        cur_set <= 8'h09;
        repeat (30) @(posedge core_clk);
        cur_set <= hi();
        repeat (2) @(posedge core_clk);
        cur_set <= 8'h09;
        repeat (30) @(posedge core_clk);
        `CHK(blink_alarm, 1'b0)
        repeat (3 * TC) @(posedge core_clk);
        `CHK(blink_alarm, 1'b1)
        test_done;
    end
endmodule
